// >>> verilog/lssp_map.svh
`ifndef LSSP_MAP_SVH
`define LSSP_MAP_SVH

// Transfer lengths and bit counter limit, in serial clocks
`define LSSP_LEN_CTRL 6'h08
`define LSSP_LEN_DIV 6'h10
`define LSSP_LEN_REF 6'h18
`define LSSP_CNT_MAX 6'h21

// Read select bits inside control_word
`define LSSP_CTRL_READ_STATUS 0
`define LSSP_CTRL_READ_COUNT 1

// Reset values of the write-only registers
`define LSSP_CTRL_RST 8'h00
`define LSSP_DIV_RST 16'h0000
`define LSSP_REF_RST 24'h00_0000

`endif

// >>> verilog/lssp_pkg.sv
package lssp_pkg;

  typedef enum logic [1:0] {
    LSSP_IDLE,
    LSSP_ACTIVE,
    LSSP_DESYNC
  } lssp_state_t;

  // Filtered serial pin levels
  typedef struct packed {
    logic sel_n;
    logic sclk;
    logic sdi;
  } lssp_pins_t;

  // Words read back through the port
  typedef struct packed {
    logic [7:0] status;
    logic status_extra;
    logic [23:0] count;
  } lssp_read_t;

endpackage : lssp_pkg

// >>> verilog/lssp_pin_sync.sv
`timescale 1ns/1ns
`default_nettype none

// Three sampling flops plus a level flop; the level moves only once the last two agree, which rejects
// single-sample glitches on slow serial edges.
module lssp_pin_sync #(
  parameter logic RST_VAL = 1'b0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic pin,
  output logic level
);

  logic ff1;
  logic ff2;
  logic ff3;
  logic next_level;

  always_comb
  begin
    next_level = level;
    if (ff2 == ff3)
    begin
      next_level = ff3;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ff1 <= RST_VAL;
      ff2 <= RST_VAL;
      ff3 <= RST_VAL;
      level <= RST_VAL;
    end
    else
    begin
      ff1 <= pin;
      ff2 <= ff1;
      ff3 <= ff2;
      level <= next_level;
    end
  end

endmodule : lssp_pin_sync

`default_nettype wire

// >>> verilog/lssp_port.sv
// Notes on behaviour
// - Data in is taken on each serial clock rise, most significant bit first.
// - 8 clocks load control, 16 divider, 24 reference; last bit is LSB.
// - Write-only registers hold their old value while bits shift in.
// - Select rising copies shifted data into the register matching the count.
// - No address bits; every stream bit is data; registers in any order.
// - Data out changes on serial clock falls, most significant bit first.
// - Oversampled shifter needs each serial clock level held two or more system clocks, continuous or intermittent.
// - Status read takes 8, 9 or 16 clocks; count read takes 24.
// - Host sets the matching read select bit in control before reading.
// - Select high blocks shifting, floats data out, holds port initialized.
// - After desync the port recovers when select is high and clock low.
// - Status shifts bit 7 first plus a ninth bit; count shifts bit 23 first.
`timescale 1ns/1ns
`default_nettype none
`include "lssp_map.svh"

module lssp_port
  import lssp_pkg::*;
#(
  parameter int CNT_W = 6,
  parameter int OUT_W = 25
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic port_select_n,
  input wire logic sclk,
  input wire logic sdi,
  output logic sdo,
  output logic sdo_oe,
  input wire lssp_read_t read_words,
  output logic [7:0] control_word,
  output logic [15:0] divider_word,
  output logic [23:0] reference_word,
  output logic desync
);

  lssp_pins_t pins;
  lssp_pins_t pins_prev;
  lssp_state_t state;
  lssp_state_t next_state;
  logic [23:0] in_sr;
  logic [23:0] next_in_sr;
  logic [CNT_W-1:0] bit_cnt;
  logic [CNT_W-1:0] next_bit_cnt;
  logic [OUT_W-1:0] out_sr;
  logic [OUT_W-1:0] next_out_sr;
  logic next_sdo;
  logic next_sdo_oe;
  logic [7:0] next_control_word;
  logic [15:0] next_divider_word;
  logic [23:0] next_reference_word;
  logic sclk_rise;
  logic sclk_fall;
  logic sel_fall;
  logic sel_rise;

  lssp_pin_sync #(.RST_VAL(1'b1)) u_sync_sel (
    .clk(clk),
    .rst(rst),
    .pin(port_select_n),
    .level(pins.sel_n)
  );

  lssp_pin_sync #(.RST_VAL(1'b0)) u_sync_sclk (
    .clk(clk),
    .rst(rst),
    .pin(sclk),
    .level(pins.sclk)
  );

  lssp_pin_sync #(.RST_VAL(1'b0)) u_sync_sdi (
    .clk(clk),
    .rst(rst),
    .pin(sdi),
    .level(pins.sdi)
  );

  // Edges come from filtered levels, so each edge is a single system clock pulse
  assign sclk_rise = pins.sclk & ~pins_prev.sclk;
  assign sclk_fall = ~pins.sclk & pins_prev.sclk;
  assign sel_fall = ~pins.sel_n & pins_prev.sel_n;
  assign sel_rise = pins.sel_n & ~pins_prev.sel_n;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pins_prev <= '{sel_n: 1'b1, sclk: 1'b0, sdi: 1'b0};
    end
    else
    begin
      pins_prev <= pins;
    end
  end

  // Port sequencing and the input shifter
  always_comb
  begin
    next_state = state;
    next_in_sr = in_sr;
    next_bit_cnt = bit_cnt;
    case (state)
      LSSP_IDLE:
      begin
        next_bit_cnt = '0;
        // A select fall seen with the clock high cannot be trusted
        if (sel_fall && pins.sclk)
        begin
          next_state = LSSP_DESYNC;
        end
        else if (sel_fall)
        begin
          next_state = LSSP_ACTIVE;
        end
      end
      LSSP_ACTIVE:
      begin
        if (sel_rise)
        begin
          next_bit_cnt = '0;
          next_state = pins.sclk ? LSSP_DESYNC : LSSP_IDLE;
        end
        else if (sclk_rise)
        begin
          next_in_sr = {in_sr[22:0], pins.sdi};
          if (bit_cnt != `LSSP_CNT_MAX)
          begin
            next_bit_cnt = bit_cnt + 1'b1;
          end
        end
      end
      LSSP_DESYNC:
      begin
        next_bit_cnt = '0;
        if (pins.sel_n && !pins.sclk)
        begin
          next_state = LSSP_IDLE;
        end
      end
      default:
      begin
        next_state = LSSP_DESYNC;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state <= LSSP_IDLE;
      in_sr <= 24'h00_0000;
      bit_cnt <= '0;
    end
    else
    begin
      state <= next_state;
      in_sr <= next_in_sr;
      bit_cnt <= next_bit_cnt;
    end
  end

  // Write-only registers change only at a clean end of transfer
  always_comb
  begin
    next_control_word = control_word;
    next_divider_word = divider_word;
    next_reference_word = reference_word;
    if (state == LSSP_ACTIVE && sel_rise && !pins.sclk)
    begin
      case (bit_cnt)
        `LSSP_LEN_CTRL:
        begin
          next_control_word = in_sr[7:0];
        end
        `LSSP_LEN_DIV:
        begin
          next_divider_word = in_sr[15:0];
        end
        `LSSP_LEN_REF:
        begin
          next_reference_word = in_sr;
        end
        default:
        begin
          next_control_word = control_word;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      control_word <= `LSSP_CTRL_RST;
      divider_word <= `LSSP_DIV_RST;
      reference_word <= `LSSP_REF_RST;
    end
    else
    begin
      control_word <= next_control_word;
      divider_word <= next_divider_word;
      reference_word <= next_reference_word;
    end
  end

  // Output shifter: loaded at select fall so the first bit is on the pin
  // before the first rise; a status read past 9 clocks just shifts zeros.
  always_comb
  begin
    next_out_sr = out_sr;
    next_sdo_oe = 1'b0;
    if (state == LSSP_IDLE && sel_fall && !pins.sclk)
    begin
      if (control_word[`LSSP_CTRL_READ_STATUS])
      begin
        next_out_sr = {read_words.status, read_words.status_extra, 16'h0000};
      end
      else if (control_word[`LSSP_CTRL_READ_COUNT])
      begin
        next_out_sr = {read_words.count, 1'b0};
      end
      else
      begin
        next_out_sr = '0;
      end
      next_sdo_oe = 1'b1;
    end
    else if (state == LSSP_ACTIVE && !sel_rise)
    begin
      next_sdo_oe = 1'b1;
      if (sclk_fall)
      begin
        next_out_sr = {out_sr[OUT_W-2:0], 1'b0};
      end
    end
    else if (state != LSSP_ACTIVE)
    begin
      next_out_sr = '0;
    end
    next_sdo = next_sdo_oe ? next_out_sr[OUT_W-1] : 1'b0;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      out_sr <= '0;
      sdo <= 1'b0;
      sdo_oe <= 1'b0;
      desync <= 1'b0;
    end
    else
    begin
      out_sr <= next_out_sr;
      sdo <= next_sdo;
      sdo_oe <= next_sdo_oe;
      desync <= (next_state == LSSP_DESYNC);
    end
  end

endmodule : lssp_port

`default_nettype wire

// >>> verilog/lssp_port_unused_placeholder_never.sv
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

// >>> testbench/lssp_port_props.sv
`timescale 1ns/1ns
`default_nettype none
module lssp_port_props
  import lssp_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic port_select_n,
  input wire logic sclk,
  input wire logic sdo,
  input wire logic sdo_oe,
  input wire logic [7:0] control_word,
  input wire logic [15:0] divider_word,
  input wire logic [23:0] reference_word,
  input wire logic desync
);
  wire [47:0] words;
  assign words = {control_word, divider_word, reference_word};
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_idle_no_drive: assert property (port_select_n [*8] |-> !sdo_oe)
    else $error("data out driven while deselected");
  a_sdo_low_off: assert property (!sdo_oe |-> !sdo)
    else $error("data out high while disabled");
  a_hold_shift: assert property (!port_select_n [*8] |=> $stable(words))
    else $error("word moved during shifting");
  a_load_on_rise: assert property ($changed(words) |-> port_select_n)
    else $error("word moved with select low");
  a_oe_on_fall: assert property ($fell(port_select_n) && !sclk && !desync |-> ##[3:9] sdo_oe)
    else $error("data out not enabled");
  a_desync_set: assert property ($rose(port_select_n) && sclk |-> ##[3:9] desync)
    else $error("desync not flagged");
  a_resync_now: assert property ((port_select_n && !sclk) [*8] |-> !desync)
    else $error("no resync");
  a_desync_quiet: assert property (desync |-> !sdo_oe && $stable(words))
    else $error("activity while desynced");
endmodule : lssp_port_props
bind lssp_port lssp_port_props chk (.clk(clk), .rst(rst), .port_select_n(port_select_n),
  .sclk(sclk), .sdo(sdo), .sdo_oe(sdo_oe), .control_word(control_word),
  .divider_word(divider_word), .reference_word(reference_word), .desync(desync));
`default_nettype wire

// >>> testbench/lssp_host.sv
`timescale 1ns/1ns
`default_nettype none
module lssp_host (
  input wire logic clk,
  input wire logic sdo,
  input wire logic sdo_oe,
  output logic port_select_n,
  output logic sclk,
  output logic sdi
);
  initial
  begin
    port_select_n = 1'b1;
    sclk = 1'b0;
    sdi = 1'b0;
  end
  task automatic gap();
    repeat (10) @(posedge clk);
  endtask : gap
  // Sample just before each rise; a released line reads low because sdo is ANDed with sdo_oe
  task automatic xfer(input int n, input logic [23:0] d, input bit bad, output logic [23:0] q);
    q = 24'h00_0000;
    port_select_n <= 1'b0;
    gap();
    for (int i = n - 1; i >= 0; i--)
    begin
      sdi <= d[i];
      gap();
      q = {q[22:0], sdo_oe & sdo};
      sclk <= 1'b1;
      gap();
      if (!(bad && i == 0))
        sclk <= 1'b0;
    end
    gap();
    port_select_n <= 1'b1;
    sdi <= ~sdi;
    gap();
    sclk <= 1'b0;
    gap();
  endtask : xfer
endmodule : lssp_host
`default_nettype wire

// >>> testbench/lssp_port_bench.sv
`timescale 1ns/1ns
`default_nettype none
`include "lssp_map.svh"
module lssp_port_bench
  import lssp_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic port_select_n, sclk, sdi, sdo, sdo_oe, desync;
  lssp_read_t read_words = '{status: 8'hA5, status_extra: 1'b1, count: 24'hC3_5A1E};
  logic [7:0] control_word;
  logic [15:0] divider_word;
  logic [23:0] reference_word;
  logic [23:0] q;
  int err_count = 0;
  int tests_run = 0;
  int cycles = 0;
  always #2 clk = ~clk;
  lssp_port uut (.clk(clk), .rst(rst), .port_select_n(port_select_n), .sclk(sclk),
    .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe), .read_words(read_words),
    .control_word(control_word), .divider_word(divider_word),
    .reference_word(reference_word), .desync(desync));
  lssp_host host (.clk(clk), .sdo(sdo), .sdo_oe(sdo_oe), .port_select_n(port_select_n),
    .sclk(sclk), .sdi(sdi));
  task automatic check(input string name, input logic [23:0] exp, input logic [23:0] got);
    tests_run++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  task automatic conclude();
    if (err_count == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : conclude
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      err_count++;
      conclude();
    end
  end
  task automatic t_writes();
    host.xfer(24, 24'h9A_BCDE, 0, q);
    host.xfer(8, 24'h00_00C4, 0, q);
    host.xfer(16, 24'h00_5A3C, 0, q);
    check("ref", 24'h9A_BCDE, reference_word);
    check("ctrl", 24'h00_00C4, {16'h0000, control_word});
    check("div", 24'h00_5A3C, {8'h00, divider_word});
  endtask : t_writes
  task automatic t_bad();
    host.xfer(12, 24'h00_0FFF, 0, q);
    check("ctrl", 24'h00_00C4, {16'h0000, control_word});
    check("div", 24'h00_5A3C, {8'h00, divider_word});
  endtask : t_bad
  task automatic t_status();
    int lens[3] = '{8, 9, 16};
    logic [23:0] s;
    s = {read_words.status, read_words.status_extra, 15'h0000};
    host.xfer(8, 24'h00_0001, 0, q);
    foreach (lens[k])
    begin
      host.xfer(lens[k], 24'h00_0001, 0, q);
      check("status", s >> (24 - lens[k]), q);
    end
  endtask : t_status
  task automatic t_count();
    host.xfer(8, 24'h00_0002, 0, q);
    host.xfer(24, 24'h12_3456, 0, q);
    check("count", read_words.count, q);
    check("ref", 24'h12_3456, reference_word);
  endtask : t_count
  task automatic t_desync();
    host.xfer(8, 24'h00_00FF, 1, q);
    check("ctrl", 24'h00_0002, {16'h0000, control_word});
    host.xfer(8, 24'h00_0081, 0, q);
    check("ctrl", 24'h00_0081, {16'h0000, control_word});
  endtask : t_desync
  initial
  begin
    repeat (6) @(posedge clk);
    check("rst", {`LSSP_CTRL_RST, `LSSP_DIV_RST}, {control_word, divider_word});
    check("rst", `LSSP_REF_RST, reference_word);
    rst <= 1'b0;
    @(posedge clk);
    t_writes();
    t_bad();
    t_status();
    t_count();
    t_desync();
    conclude();
  end
endmodule : lssp_port_bench
`default_nettype wire
